// >>> core/dpl_consts.vh
`ifndef DPL_CONSTS_VH
`define DPL_CONSTS_VH

// Register byte offsets within the block window
`define DPL_OFF_STATUS 8'h00
`define DPL_OFF_ADDR_LO 8'h04
`define DPL_OFF_ADDR_HI 8'h08
`define DPL_OFF_IRQ_STAT 8'h0c
`define DPL_OFF_IRQ_CLR 8'h10
`define DPL_OFF_IRQ_EN 8'h14

// Status register field positions
`define DPL_LOGGED_BIT 31
`define DPL_OVERRUN_BIT 30
`define DPL_ADDRV_BIT 29
`define DPL_MODEL_HI 23
`define DPL_MODEL_LO 16
`define DPL_TGT_HI 7
`define DPL_TGT_LO 5
`define DPL_ORG_HI 4
`define DPL_ORG_LO 2
`define DPL_ACC_HI 1
`define DPL_ACC_LO 0

// Address register field positions
`define DPL_ALO_HI 31
`define DPL_ALO_LO 2
`define DPL_AHI_HI 15
`define DPL_AHI_LO 0

// Reset values
`define DPL_RST_STATUS 32'h0000_0000
`define DPL_RST_ADDR 32'h0000_0000
`define DPL_MODEL_VAL 8'h00

// Target class codes
`define DPL_TGT_GENERIC 3'h0
`define DPL_TGT_DRAM 3'h1
`define DPL_TGT_MMIO 3'h2
`define DPL_TGT_IO 3'h4
`define DPL_TGT_CFG 3'h5

// Origin class codes
`define DPL_ORG_GENERIC 3'h0
`define DPL_ORG_CPU 3'h1
`define DPL_ORG_IODEV 3'h2

// Access kind codes
`define DPL_ACC_GENERIC 2'h0
`define DPL_ACC_READ 2'h1
`define DPL_ACC_WRITE 2'h2
`define DPL_ACC_RMW 2'h3

// Interrupt event bits
`define DPL_IRQ_LOGGED 0
`define DPL_IRQ_OVERRUN 1
`define DPL_IRQ_W 2

// AHB encodings
`define DPL_HSIZE_WORD 3'h2

`endif

// >>> core/dpl_ahb_if.v
`timescale 1ns/1ps
`default_nettype none
`include "dpl_consts.vh"

module dpl_ahb_if (
   input wire hclk, // Bus clock
   input wire hresetn, // Async reset, active low
   input wire hsel, // Slave select
   input wire [31:0] haddr, // Address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write when high
   input wire [2:0] hsize, // Transfer size
   input wire hready, // Bus ready
   output reg hreadyout, // Slave ready, registered
   output reg hresp, // Always OKAY
   output wire wr_stb, // Write commit pulse
   output wire rd_stb, // Read sample pulse
   output wire [31:0] acc_addr // Data phase address
);

   reg dphase_r;
   reg dwrite_r;
   reg dword_r;
   reg [31:0] daddr_r;
   wire accept;

   // Address phase taken on NONSEQ or SEQ with bus ready
   assign accept = hsel & htrans[1] & hready;

   // Data phase tracking; reads get one wait state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase_r <= 1'b0;
         dwrite_r <= 1'b0;
         dword_r <= 1'b0;
         daddr_r <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (accept) begin
            dphase_r <= 1'b1;
            dwrite_r <= hwrite;
            dword_r <= (hsize == `DPL_HSIZE_WORD);
            daddr_r <= haddr;
            hreadyout <= hwrite;
         end else if (rd_stb) begin
            hreadyout <= 1'b1;
         end else if (hready) begin
            dphase_r <= 1'b0;
         end
      end
   end

   // Strobes toward the register file
   assign rd_stb = dphase_r & ~dwrite_r & ~hreadyout;
   assign wr_stb = dphase_r & dwrite_r & dword_r & hready;
   assign acc_addr = daddr_r;

endmodule
`default_nettype wire

// >>> core/dpl_irq_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "dpl_consts.vh"

module dpl_irq_ctl (
   input wire hclk, // Bus clock
   input wire hresetn, // Async reset, active low
   input wire [`DPL_IRQ_W-1:0] ev, // Event pulses
   input wire clr_we, // Clear register write
   input wire en_we, // Enable register write
   input wire [`DPL_IRQ_W-1:0] wdata, // Write data
   output reg [`DPL_IRQ_W-1:0] status, // Sticky events
   output reg [`DPL_IRQ_W-1:0] enable, // Event enables
   output reg irq // Level interrupt
);

   reg [`DPL_IRQ_W-1:0] status_nxt;
   reg [`DPL_IRQ_W-1:0] enable_nxt;

   // Sticky bits; a new event wins over a clear
   always @* begin
      status_nxt = status;
      enable_nxt = enable;
      if (clr_we) begin
         status_nxt = status & ~wdata;
      end
      status_nxt = status_nxt | ev;
      if (en_we) begin
         enable_nxt = wdata;
      end
   end

   // Registered state and interrupt level
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= {`DPL_IRQ_W{1'b0}};
         enable <= {`DPL_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         status <= status_nxt;
         enable <= enable_nxt;
         irq <= |(status_nxt & enable_nxt);
      end
   end

endmodule
`default_nettype wire

// >>> core/dpl_error_log.v
`timescale 1ns/1ps
`default_nettype none
`include "dpl_consts.vh"


module dpl_error_log (
   input wire hclk, // Bus clock, 125 MHz
   input wire hresetn, // Cold reset, async, active low
   input wire hsel, // Slave select
   input wire [31:0] haddr, // Byte address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write when high
   input wire [2:0] hsize, // Transfer size
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   output wire [31:0] hrdata, // Read data
   output wire hreadyout, // Slave ready
   output wire hresp, // Response, always OKAY
   input wire viol_detect, // Blocked transaction pulse
   input wire [2:0] viol_target_class, // Target class code
   input wire [2:0] viol_origin_class, // Requester class code
   input wire [1:0] viol_access_kind, // Access kind code
   input wire viol_has_address, // Address present
   input wire [47:2] violation_address, // Blocked address
   output wire irq // Level interrupt
);

   // Register window decode
   function hit;
      input [31:0] addr;
      input [7:0] off;
      begin
         hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
      end
   endfunction

   // Reserved target codes fall back to generic
   function [2:0] clean_target;
      input [2:0] code;
      begin
         case (code)
            `DPL_TGT_DRAM: clean_target = `DPL_TGT_DRAM;
            `DPL_TGT_MMIO: clean_target = `DPL_TGT_MMIO;
            `DPL_TGT_IO: clean_target = `DPL_TGT_IO;
            `DPL_TGT_CFG: clean_target = `DPL_TGT_CFG;
            default: clean_target = `DPL_TGT_GENERIC;
         endcase
      end
   endfunction

   // Reserved origin codes fall back to generic
   function [2:0] clean_origin;
      input [2:0] code;
      begin
         case (code)
            `DPL_ORG_CPU: clean_origin = `DPL_ORG_CPU;
            `DPL_ORG_IODEV: clean_origin = `DPL_ORG_IODEV;
            default: clean_origin = `DPL_ORG_GENERIC;
         endcase
      end
   endfunction

   // Reset images of the log registers; fields are cut from these
   localparam [31:0] rst_status_img = `DPL_RST_STATUS;
   localparam [31:0] rst_addr_img = `DPL_RST_ADDR;

   // Bus front end wires
   wire wr_stb;
   wire rd_stb;
   wire [31:0] acc_addr;

   // Register select strobes
   wire wr_status;
   wire wr_addr_lo;
   wire wr_addr_hi;
   wire wr_irq_clr;
   wire wr_irq_en;

   // Register read selects
   wire rd_status;
   wire rd_addr_lo;
   wire rd_addr_hi;
   wire rd_irq_stat;
   wire rd_irq_en;

   // Status fields as carried by the write data
   wire sw_logged;
   wire sw_overrun;
   wire sw_addrv;
   wire [2:0] sw_target;
   wire [2:0] sw_origin;
   wire [1:0] sw_access;

   // Violation log state
   reg logged_r;
   reg overrun_r;
   reg addrv_r;
   reg [2:0] target_r;
   reg [2:0] origin_r;
   reg [1:0] access_r;
   reg [29:0] addr_lo_r;
   reg [15:0] addr_hi_r;
   reg [31:0] hrdata_r;

   // Next values
   reg logged_nxt;
   reg overrun_nxt;
   reg addrv_nxt;
   reg [2:0] target_nxt;
   reg [2:0] origin_nxt;
   reg [1:0] access_nxt;
   reg [29:0] addr_lo_nxt;
   reg [15:0] addr_hi_nxt;

   // Read mux output
   reg [31:0] rd_word;
   wire [31:0] status_word;

   // Interrupt side
   wire capture;
   wire overrun_ev;
   wire [`DPL_IRQ_W-1:0] irq_status;
   wire [`DPL_IRQ_W-1:0] irq_enable;
   wire [`DPL_IRQ_W-1:0] irq_ev;
   wire [31:0] irq_stat_word;
   wire [31:0] irq_en_word;

   // Violation inputs after code clean-up
   wire [2:0] viol_target_clean;
   wire [2:0] viol_origin_clean;
   wire addr_take;

   // AHB-Lite slave front end
   dpl_ahb_if dpl_ahb_if_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .acc_addr(acc_addr)
   );

   // Write decode per register
   assign wr_status = wr_stb & hit(acc_addr, `DPL_OFF_STATUS);
   assign wr_addr_lo = wr_stb & hit(acc_addr, `DPL_OFF_ADDR_LO);
   assign wr_addr_hi = wr_stb & hit(acc_addr, `DPL_OFF_ADDR_HI);
   assign wr_irq_clr = wr_stb & hit(acc_addr, `DPL_OFF_IRQ_CLR);
   assign wr_irq_en = wr_stb & hit(acc_addr, `DPL_OFF_IRQ_EN);

   // Read decode per register
   assign rd_status = hit(acc_addr, `DPL_OFF_STATUS);
   assign rd_addr_lo = hit(acc_addr, `DPL_OFF_ADDR_LO);
   assign rd_addr_hi = hit(acc_addr, `DPL_OFF_ADDR_HI);
   assign rd_irq_stat = hit(acc_addr, `DPL_OFF_IRQ_STAT);
   assign rd_irq_en = hit(acc_addr, `DPL_OFF_IRQ_EN);

   // Software view of the status fields
   assign sw_logged = hwdata[`DPL_LOGGED_BIT];
   assign sw_overrun = hwdata[`DPL_OVERRUN_BIT];
   assign sw_addrv = hwdata[`DPL_ADDRV_BIT];
   assign sw_target = hwdata[`DPL_TGT_HI:`DPL_TGT_LO];
   assign sw_origin = hwdata[`DPL_ORG_HI:`DPL_ORG_LO];
   assign sw_access = hwdata[`DPL_ACC_HI:`DPL_ACC_LO];

   // A violation is recorded only while no earlier one is held
   assign capture = viol_detect & ~logged_r;
   assign overrun_ev = viol_detect & logged_r;

   // Reserved class codes are logged as generic
   assign viol_target_clean = clean_target(viol_target_class);
   assign viol_origin_clean = clean_origin(viol_origin_class);
   assign addr_take = capture & viol_has_address;

   // Logged flag: hardware set wins over a software write
   always @* begin
      logged_nxt = logged_r;
      if (wr_status) begin
         logged_nxt = sw_logged;
      end
      if (capture) begin
         logged_nxt = 1'b1;
      end
   end

   // Overrun flag: set when a violation finds the log full
   always @* begin
      overrun_nxt = overrun_r;
      if (wr_status) begin
         overrun_nxt = sw_overrun;
      end
      if (overrun_ev) begin
         overrun_nxt = 1'b1;
      end
   end

   // Address valid follows whether the logged violation had an address
   always @* begin
      addrv_nxt = addrv_r;
      if (wr_status) begin
         addrv_nxt = sw_addrv;
      end
      if (capture) begin
         addrv_nxt = viol_has_address;
      end
   end

   // Error type fields: loaded by hardware, writable by software
   always @* begin
      target_nxt = target_r;
      origin_nxt = origin_r;
      access_nxt = access_r;
      if (wr_status) begin
         target_nxt = sw_target;
         origin_nxt = sw_origin;
         access_nxt = sw_access;
      end
      if (capture) begin
         target_nxt = viol_target_clean;
         origin_nxt = viol_origin_clean;
         access_nxt = viol_access_kind;
      end
   end

   // Captured address, only when the violation carries one
   always @* begin
      addr_lo_nxt = addr_lo_r;
      addr_hi_nxt = addr_hi_r;
      if (wr_addr_lo) begin
         addr_lo_nxt = hwdata[`DPL_ALO_HI:`DPL_ALO_LO];
      end
      if (wr_addr_hi) begin
         addr_hi_nxt = hwdata[`DPL_AHI_HI:`DPL_AHI_LO];
      end
      if (addr_take) begin
         addr_lo_nxt = violation_address[31:2];
         addr_hi_nxt = violation_address[47:32];
      end
   end

   // Status flags
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         logged_r <= rst_status_img[`DPL_LOGGED_BIT];
         overrun_r <= rst_status_img[`DPL_OVERRUN_BIT];
         addrv_r <= rst_status_img[`DPL_ADDRV_BIT];
      end else begin
         logged_r <= logged_nxt;
         overrun_r <= overrun_nxt;
         addrv_r <= addrv_nxt;
      end
   end

   // Error type fields
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         target_r <= rst_status_img[`DPL_TGT_HI:`DPL_TGT_LO];
         origin_r <= rst_status_img[`DPL_ORG_HI:`DPL_ORG_LO];
         access_r <= rst_status_img[`DPL_ACC_HI:`DPL_ACC_LO];
      end else begin
         target_r <= target_nxt;
         origin_r <= origin_nxt;
         access_r <= access_nxt;
      end
   end

   // Address registers clear on cold reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_lo_r <= rst_addr_img[`DPL_ALO_HI:`DPL_ALO_LO];
         addr_hi_r <= rst_addr_img[`DPL_AHI_HI:`DPL_AHI_LO];
      end else begin
         addr_lo_r <= addr_lo_nxt;
         addr_hi_r <= addr_hi_nxt;
      end
   end

   // Status word as software sees it
   assign status_word = {logged_r, overrun_r, addrv_r, 5'h00,
                         `DPL_MODEL_VAL, 8'h00,
                         target_r, origin_r, access_r};

   // Read mux; reserved bits and unmapped offsets read as zero
   always @* begin
      rd_word = 32'h0000_0000;
      if (rd_status) begin
         rd_word = status_word;
      end
      if (rd_addr_lo) begin
         rd_word = {addr_lo_r, 2'b00};
      end
      if (rd_addr_hi) begin
         rd_word = {16'h0000, addr_hi_r};
      end
      if (rd_irq_stat) begin
         rd_word = irq_stat_word;
      end
      if (rd_irq_en) begin
         rd_word = irq_en_word;
      end
   end

   // Read data register, loaded in the read wait cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_stb) begin
         hrdata_r <= rd_word;
      end
   end

   assign hrdata = hrdata_r;

   // Interrupt registers widened to a bus word
   assign irq_stat_word = {30'h0000_0000, irq_status};
   assign irq_en_word = {30'h0000_0000, irq_enable};

   // Interrupt events: new record and overrun
   assign irq_ev[`DPL_IRQ_LOGGED] = capture;
   assign irq_ev[`DPL_IRQ_OVERRUN] = overrun_ev;

   dpl_irq_ctl dpl_irq_ctl_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .ev(irq_ev),
      .clr_we(wr_irq_clr),
      .en_we(wr_irq_en),
      .wdata(hwdata[`DPL_IRQ_W-1:0]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(irq)
   );

endmodule
`default_nettype wire

// >>> verification/dpl_error_log_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dpl_error_log_sva (
   input wire hclk, // Bus clock
   input wire hresetn, // Reset, active low
   input wire hsel, // Slave select
   input wire [31:0] haddr, // Address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write flag
   input wire hready, // Bus ready
   input wire [31:0] hrdata, // Read data
   input wire hreadyout, // Slave ready
   input wire hresp, // Response
   input wire viol_detect, // Violation pulse
   input wire irq // Interrupt
);
   logic tk;
   logic ph_r;
   logic wr_r;
   logic [31:0] ad_r;
   // Transfer accepted at this edge
   assign tk = hsel && htrans[1] && hready;
   // Follow the data phase of the last accepted transfer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_r <= 1'b0;
         wr_r <= 1'b0;
         ad_r <= 32'h0;
      end else if (hready) begin
         ph_r <= tk;
         wr_r <= hwrite;
         ad_r <= haddr;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_rd_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait is not one cycle");
   a_wr_nowait: assert property (tk && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_rd_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a read");
   a_lo_resv: assert property ($rose(hreadyout) && ad_r == 32'h4 |-> hrdata[1:0] == 2'h0)
      else $error("low address reserved bits set");
   a_hi_resv: assert property ($rose(hreadyout) && ad_r == 32'h8 |-> hrdata[31:16] == 16'h0)
      else $error("high address reserved bits set");
   a_st_resv: assert property ($rose(hreadyout) && ad_r == 32'h0 |-> hrdata[28:8] == 21'h0)
      else $error("status reserved bits set");
   a_irq_rise: assert property ($rose(irq) |-> $past(viol_detect) || $past(ph_r && wr_r))
      else $error("interrupt rose without cause");
   a_irq_fall: assert property ($fell(irq) |-> $past(ph_r && wr_r))
      else $error("interrupt fell without a write");
endmodule
`default_nettype wire

// >>> verification/dpl_error_log_test.sv
`timescale 1ns/1ps
`default_nettype none
module dpl_error_log_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic viol_detect = 1'b0;
   logic [2:0] v_tgt = 3'h0;
   logic [2:0] v_org = 3'h0;
   logic [1:0] v_acc = 2'h0;
   logic v_ha = 1'b0;
   logic [47:2] v_addr = 46'h0;
   wire [31:0] hrdata;
   wire hreadyout;
   wire hresp;
   wire irq;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] m_st = 32'h0;
   logic [31:0] m_lo = 32'h0;
   logic [31:0] m_hi = 32'h0;
   logic [1:0] m_is = 2'h0;
   logic [1:0] m_en = 2'h0;
   logic [31:0] rd;
   logic [31:0] r;
   logic [31:0] amap [7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14, 32'h100};

   dpl_error_log dpl_error_log_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .viol_detect(viol_detect),
      .viol_target_class(v_tgt), .viol_origin_class(v_org), .viol_access_kind(v_acc),
      .viol_has_address(v_ha), .violation_address(v_addr), .irq(irq)
   );

   // Clock, 8 ns period
   always #4 hclk = ~hclk;

   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic test_done;
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= sz;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   // Word write, mirrored in the model
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 3'h2);
      case (a)
         32'h0: m_st = d & 32'he000_00ff;
         32'h4: m_lo = d & 32'hffff_fffc;
         32'h8: m_hi = d & 32'h0000_ffff;
         32'h10: m_is = m_is & ~d[1:0];
         32'h14: m_en = d[1:0];
         default: ;
      endcase
   endtask

   function automatic logic [31:0] exp_of(input logic [31:0] a);
      case (a)
         32'h0: return m_st;
         32'h4: return m_lo;
         32'h8: return m_hi;
         32'hc: return {30'h0, m_is};
         32'h14: return {30'h0, m_en};
         default: return 32'h0;
      endcase
   endfunction

   // Compare interrupt and every register with the model
   task automatic chk_all;
      @(posedge hclk);
      check({31'h0, irq}, {31'h0, |(m_is & m_en)});
      foreach (amap[i]) begin
         bus(1'b0, amap[i], 32'h0, 3'h2);
         check(rd, exp_of(amap[i]));
      end
   endtask

   // One violation cycle; keep leaves the strobe up for a back-to-back one
   task automatic viol(input logic [2:0] t, input logic [2:0] o, input logic [1:0] k, input logic ha,
                       input logic [47:2] ad, input logic keep);
      viol_detect <= 1'b1;
      v_tgt <= t;
      v_org <= o;
      v_acc <= k;
      v_ha <= ha;
      v_addr <= ad;
      @(posedge hclk);
      if (!keep) viol_detect <= 1'b0;
      if (m_st[31]) begin
         m_st[30] = 1'b1;
         m_is[1] = 1'b1;
      end else begin
         m_st[31] = 1'b1;
         m_st[29] = ha;
         m_st[7:5] = (t == 3'h3 || t > 3'h5) ? 3'h0 : t;
         m_st[4:2] = (o > 3'h2) ? 3'h0 : o;
         m_st[1:0] = k;
         m_is[0] = 1'b1;
         if (ha) begin
            m_lo = {ad[31:2], 2'h0};
            m_hi = {16'h0, ad[47:32]};
         end
      end
   endtask

   initial begin
      rd = $urandom(27);
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_all();
      wr(32'h14, 32'h3);
      for (int i = 0; i < 16; i++) begin
         viol(3'(i), 3'(i + 3), 2'(i), 1'($urandom), 46'({$urandom, $urandom}), i[0]);
         if (i[0]) viol(3'h3, 3'h7, 2'h1, 1'b1, 46'({$urandom, $urandom}), 1'b0);
         chk_all();
         if (i[2]) wr(32'h10, 32'h3);
         if (i[1]) wr(32'h0, 32'h0);
      end
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         wr(32'h0, {r[31:8], 3'h5, 3'h2, r[1:0]});
         wr(32'h4, r);
         wr(32'h8, ~r);
         bus(1'b1, 32'h4, ~r, 3'h1);
         wr(32'h18, r);
         chk_all();
      end
      wr(32'h0, 32'h0);
      wr(32'h14, 32'h0);
      wr(32'h10, 32'h3);
      viol(3'h2, 3'h1, 2'h2, 1'b0, 46'h0, 1'b0);
      chk_all();
      wr(32'h14, 32'h1);
      chk_all();
      test_done();
   end
endmodule

bind dpl_error_log dpl_error_log_sva dpl_error_log_sva_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .viol_detect(viol_detect), .irq(irq)
);
`default_nettype wire
